// ===== pom_pixel_output_mode_control.sv
// Mode control register, sync status and dual-port pixel output stage
// What this block does
// - Status bit 2 reads 0 for active-high vertical sync, 1 for active-low.
// - Green-embedded sync flag reads 1 while activity is seen, else 0.
// - That activity flag sits in bit 1 of the sync status register.
// - Status bit 0 reads 0 for negative coast polarity, 1 for positive.
// - Split bit, default 1, alternates pixels over two ports; 0 uses port A.
// - With split at 0 all port B outputs are released to high impedance.
// - Presentation bit 0 interleaves ports; 1, default, presents both every second edge.
// - Presentation bit is ignored while single-port output is selected.
// - Swap at 0 sends first and odd samples after line start to A, even to B.
// - Swap at 1 reverses ports, first sample after line start goes to B.
// - Swap bit is ignored in single-port mode; all data leaves through A.
// - Packing bit 0 gives 4:4:4, 1 gives 4:2:2 on 16 active lines.
// - In 4:2:2 green is luma, red alternates chroma, blue is high impedance.
// - Input select bit routes analog channel 0 when 0, channel 1 when 1.
// - Two-bit bandwidth code 00/01/10/11 means 75/150/300/500 MHz, default 11.
// - Clock source 0 uses internal PLL; 1 uses external pin, divide ratio ignored.
// - Clock phase adjustment still reaches the sampling clock with external clock.
`timescale 1ns/1ps
module pom_pixel_output_mode_control (
   input  wire logic                         clk,
   input  wire logic                         rstn,
   input  wire logic [7:0]                   reg_addr,
   input  wire logic                         reg_wr,
   input  wire logic [7:0]                   reg_wdata,
   input  wire logic                         reg_rd,
   output logic      [7:0]                   reg_rdata,
   output logic                              reg_rvalid,
   input  wire logic                         vsync_active_low_det,
   input  wire logic                         green_embedded_sync_det,
   input  wire logic                         coast_positive_det,
   input  wire logic [pom_pkg::PHASE_W-1:0]  phase_adjust,
   input  wire logic                         pix_valid,
   output logic                              pix_ready,
   input  wire logic [pom_pkg::PIX_W-1:0]    pix_data,
   input  wire logic                         pix_line_start,
   input  wire logic                         out_ready,
   output logic                              output_data_clock,
   output logic      [pom_pkg::PIX_W-1:0]    port_a_data,
   output logic      [2:0]                   port_a_oe,
   output logic      [pom_pkg::PIX_W-1:0]    port_b_data,
   output logic      [2:0]                   port_b_oe,
   output logic                              input_channel_sel,
   output logic      [1:0]                   bandwidth_code,
   output logic                              external_pixel_clock_sel,
   output logic                              pll_divide_ratio_ignore,
   output logic      [pom_pkg::PHASE_W-1:0]  sampling_phase
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [pom_pkg::DET_W-1:0]           det_s1;
      logic [pom_pkg::DET_W-1:0]           det_s2;
      logic [7:0]                          mode;
      logic [7:0]                          rdata;
      logic                                rvalid;
      logic [1:0][pom_pkg::PIX_W:0]        mem;
      logic                                wr_ptr;
      logic                                rd_ptr;
      logic [1:0]                          cnt;
      logic                                in_rdy;
      logic                                next_odd;
      logic [pom_pkg::PIX_W-1:0]           pend;
      logic                                dck;
      logic [pom_pkg::PIX_W-1:0]           a_data;
      logic [2:0]                          a_oe;
      logic [pom_pkg::PIX_W-1:0]           b_data;
      logic [2:0]                          b_oe;
      logic [pom_pkg::PHASE_W-1:0]         phase;
   } pom_state_t;

   pom_state_t s_ff;
   pom_state_t nxt_s;

   // Port that a sample lands on: odd samples to A unless swapped
   function automatic logic to_port_a(input logic odd, input logic swap);
      to_port_a = odd ^ swap;
   endfunction

   // 4:2:2 repack: red carries V on odd samples, U (from blue) on even
   function automatic logic [pom_pkg::PIX_W-1:0] pack(input logic [pom_pkg::PIX_W-1:0] px,
                                                      input logic pk, input logic odd);
      pack = px;
      if (pk) begin
         pack[pom_pkg::PIX_W-1 -: pom_pkg::CH_W] = odd ? px[pom_pkg::PIX_W-1 -: pom_pkg::CH_W]
                                                       : px[pom_pkg::CH_W-1:0];
         pack[pom_pkg::CH_W-1:0] = '0;
      end
   endfunction

   pom_pkg::pom_arr_t         arr;
   logic                      push;
   logic                      pop;
   logic                      cur_odd;
   logic [pom_pkg::PIX_W-1:0] cur_px;
   logic [2:0]                oe_val;
   logic [pom_pkg::PIX_W:0]   head;

   // ==========================================================
   // Next-state logic
   always_comb begin
      nxt_s   = s_ff;
      // Presentation bit only matters when the ports are split
      if (!s_ff.mode[pom_pkg::MD_SPLIT])
         arr = pom_pkg::POM_SINGLE;
      else if (s_ff.mode[pom_pkg::MD_SIMUL])
         arr = pom_pkg::POM_SIMUL;
      else
         arr = pom_pkg::POM_INTER;
      head    = s_ff.mem[s_ff.rd_ptr];
      push    = pix_valid && s_ff.in_rdy;
      pop     = (s_ff.cnt != 2'h0) && out_ready;
      // Line start restarts the odd/even count at the first sample
      cur_odd = head[pom_pkg::PIX_W] || s_ff.next_odd;
      cur_px  = pack(head[pom_pkg::PIX_W-1:0], s_ff.mode[pom_pkg::MD_PACK422], cur_odd);
      // Blue lines drop out in 4:2:2, so 16 lines stay active
      oe_val  = s_ff.mode[pom_pkg::MD_PACK422] ? pom_pkg::OE_NO_BLUE : pom_pkg::OE_ALL;

      // Detector levels come from the analog side, so two stages first
      nxt_s.det_s1 = {vsync_active_low_det, green_embedded_sync_det, coast_positive_det};
      nxt_s.det_s2 = s_ff.det_s1;

      // Only the mode register takes writes; status writes fall away
      if (reg_wr && reg_addr == pom_pkg::MODE_ADDR)
         nxt_s.mode = reg_wdata;
      nxt_s.rvalid = reg_rd;
      if (reg_rd) begin
         if (reg_addr == pom_pkg::STATUS_ADDR)
            nxt_s.rdata = {5'h00, s_ff.det_s2};
         else if (reg_addr == pom_pkg::MODE_ADDR)
            nxt_s.rdata = s_ff.mode;
         else
            nxt_s.rdata = 8'h00;
      end

      // Two-entry buffer: ready is registered, so full stalls the source
      if (push) begin
         nxt_s.mem[s_ff.wr_ptr] = {pix_line_start, pix_data};
         nxt_s.wr_ptr           = ~s_ff.wr_ptr;
      end
      if (pop)
         nxt_s.rd_ptr = ~s_ff.rd_ptr;
      nxt_s.cnt    = s_ff.cnt + {1'b0, push} - {1'b0, pop};
      nxt_s.in_rdy = (nxt_s.cnt != pom_pkg::FIFO_DEPTH);

      // Port drivers follow the mode; port B floats in single mode
      nxt_s.a_oe = oe_val;
      nxt_s.b_oe = s_ff.mode[pom_pkg::MD_SPLIT] ? oe_val : pom_pkg::OE_NONE;

      // Output stage; the data clock strobe marks each update
      nxt_s.dck = 1'b0;
      if (pop) begin
         nxt_s.next_odd = ~cur_odd;
         case (arr)
            pom_pkg::POM_SINGLE: begin
               // Swap is not looked at here
               nxt_s.a_data = cur_px;
               nxt_s.dck    = 1'b1;
            end
            pom_pkg::POM_INTER: begin
               if (to_port_a(cur_odd, s_ff.mode[pom_pkg::MD_SWAP]))
                  nxt_s.a_data = cur_px;
               else
                  nxt_s.b_data = cur_px;
               nxt_s.dck = 1'b1;
            end
            pom_pkg::POM_SIMUL: begin
               // Hold the first of a pair, present both with the second
               if (cur_odd) begin
                  nxt_s.pend = cur_px;
               end else begin
                  if (s_ff.mode[pom_pkg::MD_SWAP]) begin
                     nxt_s.a_data = cur_px;
                     nxt_s.b_data = s_ff.pend;
                  end else begin
                     nxt_s.a_data = s_ff.pend;
                     nxt_s.b_data = cur_px;
                  end
                  nxt_s.dck = 1'b1;
               end
            end
            default: begin
               nxt_s.dck = 1'b0;
            end
         endcase
      end

      // Phase setting passes whichever clock source is chosen
      nxt_s.phase = phase_adjust;
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_ff        <= '0;
         s_ff.mode   <= pom_pkg::MODE_RESET;
         s_ff.in_rdy <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   assign reg_rdata                = s_ff.rdata;
   assign reg_rvalid               = s_ff.rvalid;
   assign pix_ready                = s_ff.in_rdy;
   assign output_data_clock        = s_ff.dck;
   assign port_a_data              = s_ff.a_data;
   assign port_a_oe                = s_ff.a_oe;
   assign port_b_data              = s_ff.b_data;
   assign port_b_oe                = s_ff.b_oe;
   assign input_channel_sel        = s_ff.mode[pom_pkg::MD_INSEL];
   assign bandwidth_code           = s_ff.mode[pom_pkg::MD_BW_HI:pom_pkg::MD_BW_LO];
   assign external_pixel_clock_sel = s_ff.mode[pom_pkg::MD_EXTCLK];
   assign pll_divide_ratio_ignore  = s_ff.mode[pom_pkg::MD_EXTCLK];
   assign sampling_phase           = s_ff.phase;

   // ==========================================================
   // Checks
   vsync_pol_read_a : assert property (@(posedge clk) disable iff (!rstn)
      reg_rd && reg_addr == pom_pkg::STATUS_ADDR && $past(rstn) && $past(rstn, 2) |=>
      reg_rdata[pom_pkg::ST_VSYNC_LOW] == $past(vsync_active_low_det, 3))
      else $error("vsync polarity bit wrong");

   sog_flag_read_a : assert property (@(posedge clk) disable iff (!rstn)
      reg_rd && reg_addr == pom_pkg::STATUS_ADDR && $past(rstn) && $past(rstn, 2) |=>
      reg_rdata[pom_pkg::ST_SOG_ACTIVE] == $past(green_embedded_sync_det, 3))
      else $error("sync activity flag wrong");

   coast_pol_read_a : assert property (@(posedge clk) disable iff (!rstn)
      reg_rd && reg_addr == pom_pkg::STATUS_ADDR && $past(rstn) && $past(rstn, 2) |=>
      reg_rdata[pom_pkg::ST_COAST_POS] == $past(coast_positive_det, 3))
      else $error("coast polarity bit wrong");

   status_read_only_a : assert property (@(posedge clk) disable iff (!rstn)
      reg_wr && reg_addr == pom_pkg::STATUS_ADDR && !(reg_wr && reg_addr == pom_pkg::MODE_ADDR)
      |=> s_ff.mode == $past(s_ff.mode))
      else $error("status write changed mode");

   port_b_float_a : assert property (@(posedge clk) disable iff (!rstn)
      !s_ff.mode[pom_pkg::MD_SPLIT] ##1 !s_ff.mode[pom_pkg::MD_SPLIT] |-> port_b_oe == pom_pkg::OE_NONE)
      else $error("port B driven in single mode");

   single_to_a_a : assert property (@(posedge clk) disable iff (!rstn)
      pop && arr == pom_pkg::POM_SINGLE && !s_ff.mode[pom_pkg::MD_PACK422] |=>
      output_data_clock && port_a_data == $past(head[pom_pkg::PIX_W-1:0]))
      else $error("single-port pixel not on port A");

   first_swap_b_a : assert property (@(posedge clk) disable iff (!rstn)
      pop && arr == pom_pkg::POM_INTER && head[pom_pkg::PIX_W] && s_ff.mode[pom_pkg::MD_SWAP]
      && !s_ff.mode[pom_pkg::MD_PACK422] |=>
      output_data_clock && port_b_data == $past(head[pom_pkg::PIX_W-1:0]))
      else $error("swapped first sample not on port B");

   first_plain_a_a : assert property (@(posedge clk) disable iff (!rstn)
      pop && arr == pom_pkg::POM_INTER && head[pom_pkg::PIX_W] && !s_ff.mode[pom_pkg::MD_SWAP]
      && !s_ff.mode[pom_pkg::MD_PACK422] |=>
      output_data_clock && port_a_data == $past(head[pom_pkg::PIX_W-1:0]))
      else $error("first sample not on port A");

   simul_every_other_a : assert property (@(posedge clk) disable iff (!rstn)
      output_data_clock && arr == pom_pkg::POM_SIMUL && $past(arr) == pom_pkg::POM_SIMUL
      |=> !output_data_clock)
      else $error("simultaneous mode strobed twice in a row");

   blue_float_a : assert property (@(posedge clk) disable iff (!rstn)
      s_ff.mode[pom_pkg::MD_PACK422] ##1 s_ff.mode[pom_pkg::MD_PACK422] |->
      !port_a_oe[0] && !port_b_oe[0] && port_a_oe[2:1] == 2'h3)
      else $error("blue lines driven in 4:2:2");

endmodule // pom_pixel_output_mode_control

// ===== pom_pkg.sv
// Shared constants and types of the pixel output mode control block
package pom_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] STATUS_ADDR    = 8'h14;
   localparam logic [7:0] MODE_ADDR      = 8'h15;
   localparam logic [7:0] MODE_RESET     = 8'hc6;
   // ==========================================================
   // Status fields
   localparam int         ST_VSYNC_LOW   = 2;
   localparam int         ST_SOG_ACTIVE  = 1;
   localparam int         ST_COAST_POS   = 0;
   localparam int         DET_W          = 3;
   // ==========================================================
   // Mode control fields
   localparam int         MD_SPLIT       = 7;
   localparam int         MD_SIMUL       = 6;
   localparam int         MD_SWAP        = 5;
   localparam int         MD_PACK422     = 4;
   localparam int         MD_INSEL       = 3;
   localparam int         MD_BW_HI       = 2;
   localparam int         MD_BW_LO       = 1;
   localparam int         MD_EXTCLK      = 0;
   // ==========================================================
   // Pixel layout: red [23:16], green [15:8], blue [7:0]
   localparam int         CH_W           = 8;
   localparam int         PIX_W          = 24;
   localparam int         PHASE_W        = 5;
   localparam logic [1:0] FIFO_DEPTH     = 2'h2;
   localparam logic [2:0] OE_ALL         = 3'h7;
   localparam logic [2:0] OE_NO_BLUE     = 3'h6;
   localparam logic [2:0] OE_NONE        = 3'h0;
   // Output arrangement chosen by the split and presentation bits
   typedef enum logic [1:0] {
      POM_SINGLE = 2'b00,
      POM_INTER  = 2'b01,
      POM_SIMUL  = 2'b10
   } pom_arr_t;
endpackage

// ===== pom_pixel_sink.sv
// Downstream pixel receiver model that records every presented output pair
`timescale 1ns/1ps
module pom_pixel_sink (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       slow,
   input  wire logic                       output_data_clock,
   input  wire logic [pom_pkg::PIX_W-1:0]  port_a_data,
   input  wire logic [pom_pkg::PIX_W-1:0]  port_b_data,
   output logic                            out_ready
);
   logic                        toggle_ff;
   logic [pom_pkg::PIX_W-1:0]   qa[$];
   logic [pom_pkg::PIX_W-1:0]   qb[$];
   // ==========================================================
   // Capture on each strobe; slow mode stalls every other cycle so the buffer fills
   // Plain always: the bench empties the queues between lines
   always @(posedge clk) begin
      toggle_ff <= rstn ? ~toggle_ff : 1'b0;
      if (rstn && output_data_clock) begin
         qa.push_back(port_a_data);
         qb.push_back(port_b_data);
      end
   end
   assign out_ready = slow ? toggle_ff : 1'b1;
endmodule // pom_pixel_sink

// ===== pom_pixel_output_mode_control_tb.sv
// Self-checking bench for the pixel output mode control block
`timescale 1ns/1ps
module pom_pixel_output_mode_control_tb;
   logic                        clk = 1'b0;
   logic                        rstn = 1'b0;
   logic [7:0]                  reg_addr = 8'h00;
   logic                        reg_wr = 1'b0;
   logic [7:0]                  reg_wdata = 8'h00;
   logic                        reg_rd = 1'b0;
   logic [7:0]                  reg_rdata;
   logic                        reg_rvalid;
   logic [2:0]                  det = 3'h0;
   logic [pom_pkg::PHASE_W-1:0] phase_adjust = 5'h00;
   logic                        pix_valid = 1'b0;
   logic                        pix_ready;
   logic [pom_pkg::PIX_W-1:0]   pix_data = 24'h000000;
   logic                        pix_line_start = 1'b0;
   logic                        slow = 1'b0;
   logic                        out_ready;
   logic                        output_data_clock;
   logic [pom_pkg::PIX_W-1:0]   port_a_data;
   logic [pom_pkg::PIX_W-1:0]   port_b_data;
   logic [2:0]                  port_a_oe;
   logic [2:0]                  port_b_oe;
   logic                        input_channel_sel;
   logic [1:0]                  bandwidth_code;
   logic                        external_pixel_clock_sel;
   logic                        pll_divide_ratio_ignore;
   logic [pom_pkg::PHASE_W-1:0] sampling_phase;
   logic                        refused;
   int                          err_total = 0;
   int                          checked = 0;
   int                          cycles = 0;

   pom_pixel_output_mode_control dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .vsync_active_low_det(det[2]), .green_embedded_sync_det(det[1]), .coast_positive_det(det[0]),
      .phase_adjust(phase_adjust), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
      .pix_line_start(pix_line_start), .out_ready(out_ready), .output_data_clock(output_data_clock),
      .port_a_data(port_a_data), .port_a_oe(port_a_oe), .port_b_data(port_b_data), .port_b_oe(port_b_oe),
      .input_channel_sel(input_channel_sel), .bandwidth_code(bandwidth_code),
      .external_pixel_clock_sel(external_pixel_clock_sel),
      .pll_divide_ratio_ignore(pll_divide_ratio_ignore), .sampling_phase(sampling_phase));
   pom_pixel_sink sink (.clk(clk), .rstn(rstn), .slow(slow), .output_data_clock(output_data_clock),
      .port_a_data(port_a_data), .port_b_data(port_b_data), .out_ready(out_ready));

   // ==========================================================
   // Clock and hang guard; the whole run needs well under 5000 cycles
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Distinct red, green and blue bytes per sample so misrouting shows
   function automatic logic [23:0] px(input int i);
      return {8'h10 + 8'(i), 8'h40 + 8'(i), 8'h80 + 8'(i)};
   endfunction
   // ==========================================================
   // Register strobe port: one-cycle pulses, read answered one cycle later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk({23'h0, reg_rvalid}, 24'h1, "read strobe answer");
      chk({16'h0, reg_rdata}, {16'h0, exp}, msg);
   endtask
   // Sends one line of n samples, then waits for m strobes at the far side
   task automatic send_line(input int n, input int m);
      int g;
      sink.qa.delete();
      sink.qb.delete();
      refused = 1'b0;
      @(posedge clk);
      for (int i = 1; i <= n; i++) begin
         pix_valid <= 1'b1;
         pix_data <= px(i);
         pix_line_start <= (i == 1);
         g = 0;
         do begin
            @(posedge clk);
            g++;
            if (pix_ready !== 1'b1)
               refused = 1'b1;
         end while (pix_ready !== 1'b1 && g < 100);
      end
      pix_valid <= 1'b0;
      for (g = 0; g < 100 && sink.qa.size() < m; g++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      chk(24'(sink.qa.size()), 24'(m), "strobe count");
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset_and_status();
      chk({15'h0, reg_rdata, pix_ready}, 24'h1, "reset outputs");
      rd_chk(pom_pkg::MODE_ADDR, 8'hc6, "mode reset value");
      chk(24'({port_a_oe, port_b_oe, bandwidth_code}), 24'({3'h7, 3'h7, 2'b11}), "oe and bandwidth default");
      for (int v = 0; v < 8; v++) begin
         det <= 3'(v);
         repeat (4) @(posedge clk);
         wr(pom_pkg::STATUS_ADDR, 8'hff);
         rd_chk(pom_pkg::STATUS_ADDR, {5'h00, 3'(v)}, "status bits");
      end
      rd_chk(pom_pkg::MODE_ADDR, 8'hc6, "mode after status writes");
      rd_chk(8'h3a, 8'h00, "unmapped read");
   endtask
   task automatic t_mode_fields();
      phase_adjust <= 5'h13;
      for (int b = 0; b < 4; b++) begin
         wr(pom_pkg::MODE_ADDR, {5'h0d, 2'(b), 1'b1});
         rd_chk(pom_pkg::MODE_ADDR, {5'h0d, 2'(b), 1'b1}, "mode readback");
         chk(24'({input_channel_sel, bandwidth_code}), 24'({1'b1, 2'(b)}), "input select and bandwidth");
         chk(24'({external_pixel_clock_sel, pll_divide_ratio_ignore}), 24'(2'b11), "external clock");
         chk(24'(sampling_phase), 24'(5'h13), "phase with external clock");
      end
      wr(pom_pkg::MODE_ADDR, 8'hc6);
      @(posedge clk);
      #1;
      chk(24'({input_channel_sel, external_pixel_clock_sel, pll_divide_ratio_ignore}), 24'(3'h0), "internal clock");
   endtask
   // Single port with presentation and swap set, slow receiver forcing refusals
   task automatic t_single();
      wr(pom_pkg::MODE_ADDR, 8'h66);
      slow <= 1'b1;
      send_line(6, 6);
      slow <= 1'b0;
      chk({23'h0, refused}, 24'h1, "buffer refusal seen");
      for (int k = 0; k < 6; k++)
         chk(sink.qa[k], px(k + 1), "single port data");
      chk(24'({port_a_oe, port_b_oe}), 24'({3'h7, 3'h0}), "port b released");
   endtask
   task automatic t_dual();
      for (int s = 0; s < 2; s++)
         for (int m = 0; m < 2; m++) begin
            wr(pom_pkg::MODE_ADDR, {1'b1, 1'(m), 1'(s), 5'h06});
            send_line(4, m ? 2 : 4);
            for (int k = 0; k < (m ? 2 : 4); k++)
               if (m == 1) begin
                  chk(sink.qa[k], px(2 * k + 1 + s), "simultaneous port a");
                  chk(sink.qb[k], px(2 * k + 2 - s), "simultaneous port b");
               end else if ((k % 2 == 0) ^ (s == 1))
                  chk(sink.qa[k], px(k + 1), "interleaved port a");
               else
                  chk(sink.qb[k], px(k + 1), "interleaved port b");
            chk(24'({port_a_oe, port_b_oe}), 24'(6'h3f), "both ports driven");
         end
   endtask
   // Green carries luma in the stimulus; red alternates chroma, blue released
   task automatic t_pack422();
      logic [23:0] p1;
      logic [23:0] p2;
      p1 = px(1);
      p2 = px(2);
      wr(pom_pkg::MODE_ADDR, 8'h56);
      send_line(2, 2);
      chk(sink.qa[0], {p1[23:8], 8'h00}, "odd sample chroma");
      chk(sink.qa[1], {p2[7:0], p2[15:8], 8'h00}, "even sample chroma");
      chk(24'(port_a_oe), 24'(pom_pkg::OE_NO_BLUE), "blue released");
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      t_reset_and_status();
      t_mode_fields();
      t_single();
      t_dual();
      t_pack422();
      report_and_stop();
   end
endmodule // pom_pixel_output_mode_control_tb
